// file: rtl/rsc_pkg.sv
// package: constants and types of the reset and stop recovery controller
package rsc_pkg;

	// ********************************************************************
	// timing
	// ********************************************************************
	localparam int unsigned CLK_PERIOD_NS     = 40;
	localparam int unsigned SYS_RST_NS        = 2640;
	localparam int unsigned SYS_RST_CYCLES    = (SYS_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned XTAL_START_US     = 1000;
	localparam int unsigned XTAL_START_CYCLES =
		(XTAL_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SMR_NS            = 640;
	localparam int unsigned SMR_CYCLES        = (SMR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0]  PIN_MIN_CYCLES    = 3'h4;
	localparam int unsigned CNT_W             = 16;

	// ********************************************************************
	// widths and synchroniser layout
	// ********************************************************************
	localparam int unsigned GPIO_W   = 8;
	localparam int unsigned SYNC_W   = GPIO_W + 4;
	localparam int unsigned SY_PIN   = 0;
	localparam int unsigned SY_POR   = 1;
	localparam int unsigned SY_BO    = 2;
	localparam int unsigned SY_LVD   = 3;
	localparam int unsigned SY_GPIO  = 4;
	localparam logic [SYNC_W-1:0] SYNC_INIT = 12'h001;

	// ********************************************************************
	// register offsets, fields and reset values
	// ********************************************************************
	localparam logic [7:0] ADR_DBG    = 8'h00;
	localparam logic [7:0] ADR_CAUSE  = 8'h04;
	localparam logic [7:0] ADR_SMR_EN = 8'h08;
	localparam logic [7:0] ADR_LVD    = 8'h0c;

	localparam int unsigned DBG_RST_BIT = 0;
	localparam int unsigned CAUSE_POR   = 0;
	localparam int unsigned CAUSE_BO    = 1;
	localparam int unsigned CAUSE_WDT   = 2;
	localparam int unsigned CAUSE_PIN   = 3;
	localparam int unsigned CAUSE_DBG   = 4;
	localparam int unsigned CAUSE_SMR   = 5;
	localparam int unsigned LVD_SEL_LSB = 0;
	localparam int unsigned LVD_EN_BIT  = 3;

	localparam logic [7:0] DBG_RST_VAL   = 8'h00;
	localparam logic [7:0] CAUSE_RST_VAL = 8'h01;
	localparam logic [7:0] CAUSE_MASK    = 8'h3f;
	localparam logic [7:0] SMR_EN_RST    = 8'h00;
	localparam logic [7:0] LVD_RST_VAL   = 8'h00;

	// ********************************************************************
	// sequencer states
	// ********************************************************************
	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_HOLD  = 2'b01,
		ST_COUNT = 2'b10,
		ST_SMR   = 2'b11
	} rsc_state_t;

endpackage : rsc_pkg

// file: rtl/rsc_sync.sv
// module: two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/10ps
module rsc_sync #(
	parameter int unsigned       W    = 12,
	parameter logic [W-1:0]      INIT = '0
) (
	// system
	input  wire logic         clk,
	input  wire logic         rst_n,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					meta[i]     <= INIT[i];
					sync_out[i] <= INIT[i];
				end else begin
					meta[i]     <= async_in[i];
					sync_out[i] <= meta[i];
				end
			end
		end
	endgenerate

endmodule : rsc_sync

// file: rtl/rsc_top.sv
// module: reset sequencer with stop mode recovery and low voltage interrupt
`timescale 1ns/10ps
module rsc_top #(
	parameter int unsigned XTAL_CYCLES = rsc_pkg::XTAL_START_CYCLES
) (
	// system
	input  wire logic        clk,
	input  wire logic        rst_n,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// asynchronous pins and supply comparators
	input  wire logic        reset_pin_n,
	input  wire logic        supply_por_ok,
	input  wire logic        brownout_detect,
	input  wire logic        lvd_below,
	input  wire logic [7:0]  gpio_in,
	// same-clock status and option bits
	input  wire logic        watchdog_timeout,
	input  wire logic        watchdog_reset_select_option,
	input  wire logic        reset_pin_alt_en,
	input  wire logic        stop_mode,
	input  wire logic        xtal_enable,
	// results
	output logic             sys_reset,
	output logic             smr_active,
	output logic             wdt_irq,
	output logic             lvd_irq,
	output logic      [2:0]  lvd_threshold
);

	// ********************************************************************
	// synchronisers
	// ********************************************************************
	logic [rsc_pkg::SYNC_W-1:0] sync_q;

	rsc_sync #(
		.W    (rsc_pkg::SYNC_W),
		.INIT (rsc_pkg::SYNC_INIT)
	) u_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in ({gpio_in, lvd_below, brownout_detect, supply_por_ok, reset_pin_n}),
		.sync_out (sync_q)
	);

	wire       pin_low_s = ~sync_q[rsc_pkg::SY_PIN];
	wire       por_ok_s  = sync_q[rsc_pkg::SY_POR];
	wire       bo_s      = sync_q[rsc_pkg::SY_BO];
	wire       lvd_s     = sync_q[rsc_pkg::SY_LVD];
	wire [7:0] gpio_s    = sync_q[rsc_pkg::SY_GPIO +: rsc_pkg::GPIO_W];

	// ********************************************************************
	// registers and state
	// ********************************************************************
	rsc_pkg::rsc_state_t          state;
	rsc_pkg::rsc_state_t          next_state;
	logic [rsc_pkg::CNT_W-1:0]    cnt;
	logic [rsc_pkg::CNT_W-1:0]    next_cnt;
	logic [2:0]                   pin_cnt;
	logic [7:0]                   gpio_prev;
	logic                         lvd_prev;
	logic [7:0]                   dbg_ctl;
	logic [7:0]                   cause;
	logic [7:0]                   smr_en;
	logic [7:0]                   lvd_ctl;

	// ********************************************************************
	// register decode
	// ********************************************************************
	function automatic logic rsc_hit(input logic [7:0] adr, input logic [7:0] off);
		rsc_hit = (adr[7:2] == off[7:2]);
	endfunction : rsc_hit

	wire       bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire       wr_en     = bus_req & wb_we_i & wb_sel_i[0];
	wire       hit_dbg   = rsc_hit(wb_adr_i, rsc_pkg::ADR_DBG);
	wire       hit_cause = rsc_hit(wb_adr_i, rsc_pkg::ADR_CAUSE);
	wire       hit_smr   = rsc_hit(wb_adr_i, rsc_pkg::ADR_SMR_EN);
	wire       hit_lvd   = rsc_hit(wb_adr_i, rsc_pkg::ADR_LVD);
	wire       wr_dbg    = wr_en & hit_dbg;
	wire       wr_cause  = wr_en & hit_cause;
	wire       wr_smr    = wr_en & hit_smr;
	wire       wr_lvd    = wr_en & hit_lvd;
	wire [7:0] rd_byte   = hit_dbg   ? dbg_ctl :
	                       hit_cause ? cause   :
	                       hit_smr   ? smr_en  :
	                       hit_lvd   ? lvd_ctl : 8'h00;

	// ********************************************************************
	// request sources
	// ********************************************************************
	wire run       = (state == rsc_pkg::ST_RUN);
	wire pin_act   = (pin_cnt == rsc_pkg::PIN_MIN_CYCLES);
	wire pin_go    = pin_low_s & reset_pin_alt_en;
	wire [2:0] next_pin_cnt = !pin_go ? 3'h0 :
	                          pin_act ? pin_cnt : pin_cnt + 3'h1;
	// sources that keep reset asserted for as long as they are present
	wire hold_req  = bo_s | ~por_ok_s | pin_act;
	wire wdt_rst   = watchdog_timeout & ~stop_mode & watchdog_reset_select_option;
	wire wdt_int   = watchdog_timeout & ~stop_mode & ~watchdog_reset_select_option;
	wire dbg_rst   = dbg_ctl[rsc_pkg::DBG_RST_BIT];
	wire soft_req  = wdt_rst | dbg_rst;
	wire gpio_edge = |((gpio_s ^ gpio_prev) & smr_en);
	wire smr_req   = stop_mode & (watchdog_timeout | gpio_edge);
	wire smr_take  = run & smr_req & ~hold_req & ~soft_req;
	wire lvd_rise  = lvd_s & ~lvd_prev & lvd_ctl[rsc_pkg::LVD_EN_BIT];

	wire [rsc_pkg::CNT_W-1:0] rst_load = xtal_enable ?
		rsc_pkg::CNT_W'(rsc_pkg::SYS_RST_CYCLES - 1 + XTAL_CYCLES) :
		rsc_pkg::CNT_W'(rsc_pkg::SYS_RST_CYCLES - 1);
	wire [rsc_pkg::CNT_W-1:0] smr_load = rsc_pkg::CNT_W'(rsc_pkg::SMR_CYCLES - 1);

	// cause flags set by hardware; a set in the clearing cycle wins
	wire [7:0] cause_set;
	assign cause_set[rsc_pkg::CAUSE_POR] = ~por_ok_s;
	assign cause_set[rsc_pkg::CAUSE_BO]  = bo_s;
	assign cause_set[rsc_pkg::CAUSE_WDT] = run & (wdt_rst | (stop_mode & watchdog_timeout));
	assign cause_set[rsc_pkg::CAUSE_PIN] = pin_act;
	assign cause_set[rsc_pkg::CAUSE_DBG] = run & dbg_rst;
	assign cause_set[rsc_pkg::CAUSE_SMR] = smr_take;
	assign cause_set[7:6]                = 2'b00;
	wire [7:0] cause_clr  = wr_cause ? wb_dat_i[7:0] : 8'h00;
	wire [7:0] next_cause = ((cause & ~cause_clr) | cause_set) & rsc_pkg::CAUSE_MASK;

	// debugger request is dropped once taken, unless rewritten in that cycle
	wire [7:0] next_dbg = wr_dbg ? wb_dat_i[7:0] :
	                      (run & dbg_rst) ? (dbg_ctl & ~8'h01) : dbg_ctl;

	// ********************************************************************
	// sequencer
	// ********************************************************************
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		case (state)
			rsc_pkg::ST_RUN: begin
				if (hold_req | soft_req) begin
					next_state = rsc_pkg::ST_HOLD;
				end else if (smr_req) begin
					next_state = rsc_pkg::ST_SMR;
					next_cnt   = smr_load;
				end
			end
			rsc_pkg::ST_HOLD: begin
				// stays here while any hold source remains: supply below the power-on level, brownout, or the reset pin held
				if (!hold_req) begin
					next_state = rsc_pkg::ST_COUNT;
					next_cnt   = rst_load;
				end
			end
			rsc_pkg::ST_COUNT: begin
				if (hold_req) begin
					next_state = rsc_pkg::ST_HOLD;
				end else if (cnt == '0) begin
					next_state = rsc_pkg::ST_RUN;
				end else begin
					next_cnt = cnt - rsc_pkg::CNT_W'(1);
				end
			end
			rsc_pkg::ST_SMR: begin
				if (hold_req) begin
					next_state = rsc_pkg::ST_HOLD;
				end else if (cnt == '0) begin
					next_state = rsc_pkg::ST_RUN;
				end else begin
					next_cnt = cnt - rsc_pkg::CNT_W'(1);
				end
			end
			default: begin
				next_state = rsc_pkg::ST_HOLD;
			end
		endcase
	end

	wire next_sys_reset = (next_state == rsc_pkg::ST_HOLD) | (next_state == rsc_pkg::ST_COUNT);
	wire next_smr       = (next_state == rsc_pkg::ST_SMR);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state      <= rsc_pkg::ST_HOLD;
			cnt        <= '0;
			sys_reset  <= 1'b1;
			smr_active <= 1'b0;
		end else begin
			state      <= next_state;
			cnt        <= next_cnt;
			sys_reset  <= next_sys_reset;
			smr_active <= next_smr;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_cnt   <= 3'h0;
			gpio_prev <= 8'h00;
			lvd_prev  <= 1'b0;
			wdt_irq   <= 1'b0;
			lvd_irq   <= 1'b0;
		end else begin
			pin_cnt   <= next_pin_cnt;
			gpio_prev <= gpio_s;
			lvd_prev  <= lvd_s;
			wdt_irq   <= run & wdt_int;
			lvd_irq   <= lvd_rise;
		end
	end

	// ********************************************************************
	// register file and bus answer
	// ********************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dbg_ctl       <= rsc_pkg::DBG_RST_VAL;
			cause         <= rsc_pkg::CAUSE_RST_VAL;
			smr_en        <= rsc_pkg::SMR_EN_RST;
			lvd_ctl       <= rsc_pkg::LVD_RST_VAL;
			lvd_threshold <= rsc_pkg::LVD_RST_VAL[2:0];
			wb_ack_o      <= 1'b0;
			wb_dat_o      <= 32'h0000_0000;
		end else begin
			dbg_ctl  <= next_dbg;
			cause    <= next_cause;
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			if (wr_smr) begin
				smr_en <= wb_dat_i[7:0];
			end
			if (wr_lvd) begin
				lvd_ctl       <= wb_dat_i[7:0] & 8'h0f;
				lvd_threshold <= wb_dat_i[rsc_pkg::LVD_SEL_LSB +: 3];
			end
		end
	end

	// ********************************************************************
	// checks
	// ********************************************************************
	localparam int unsigned RST_MIN = rsc_pkg::SYS_RST_CYCLES;

	logic [rsc_pkg::CNT_W-1:0] rst_len;
	logic [7:0]                smr_len;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rst_len <= '0;
		end else if (sys_reset) begin
			rst_len <= (&rst_len) ? rst_len : rst_len + rsc_pkg::CNT_W'(1);
		end else begin
			rst_len <= '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			smr_len <= 8'h00;
		end else if (smr_active) begin
			smr_len <= (&smr_len) ? smr_len : smr_len + 8'h01;
		end else begin
			smr_len <= 8'h00;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	wdt_reset_a: assert property (run & wdt_rst & ~hold_req |=> sys_reset ##0 !smr_active)
		else $error("watchdog time-out with reset option gave no reset");
	wdt_flag_a: assert property (run & wdt_rst |=> cause[rsc_pkg::CAUSE_WDT])
		else $error("watchdog reset did not set its cause flag");
	wdt_irq_a: assert property (run & wdt_int |=> wdt_irq ##1 !wdt_irq)
		else $error("watchdog interrupt is not a one-cycle pulse");
	pin_ignore_a: assert property (!reset_pin_alt_en |=> pin_cnt == 3'h0)
		else $error("reset pin counted without alternate function");
	pin_min_a: assert property ((pin_low_s & reset_pin_alt_en) [*4] |=> pin_act ##1 sys_reset)
		else $error("reset pin held four cycles gave no reset");
	pin_early_a: assert property ($rose(pin_act) |-> $past(pin_cnt) == 3'h3)
		else $error("reset pin acted before four cycles");
	dbg_reset_a: assert property (run & dbg_rst |=>
			sys_reset ##0 (!dbg_ctl[0] || $past(wr_dbg)))
		else $error("debugger request gave no reset");
	brownout_a: assert property (bo_s |=> sys_reset)
		else $error("brownout did not hold reset");
	por_pass_a: assert property (state == rsc_pkg::ST_HOLD && !por_ok_s |=>
			state == rsc_pkg::ST_HOLD)
		else $error("reset released below power-on level");
	smr_start_a: assert property (smr_take |=> smr_active [*2] ##0 !sys_reset)
		else $error("stop recovery did not start");
	rst_len_a: assert property ($fell(sys_reset) |->
			$past(rst_len) >= RST_MIN + (xtal_enable ? XTAL_CYCLES : 0))
		else $error("system reset released too early");
	lvd_irq_a: assert property (lvd_rise |=> lvd_irq)
		else $error("low voltage gave no interrupt");

	// ********************************************************************
	// recovery, reset, cause flag, interrupt and bus answer checks
	// ********************************************************************
	smr_len_a: assert property ($fell(smr_active) && !sys_reset |->
			smr_len == rsc_pkg::SMR_CYCLES)
		else $error("stop recovery length is wrong");
	smr_stop_a: assert property ($rose(smr_active) |-> $past(stop_mode))
		else $error("stop recovery started outside stop mode");
	wdt_stop_a: assert property (smr_take & watchdog_timeout |=>
			smr_active && cause[rsc_pkg::CAUSE_WDT])
		else $error("watchdog in stop gave no recovery");
	gpio_mask_a: assert property (run & stop_mode & ~watchdog_timeout & ~gpio_edge |=>
			!smr_active)
		else $error("recovery without an enabled source");
	smr_cause_a: assert property (smr_take |=> cause[rsc_pkg::CAUSE_SMR])
		else $error("stop recovery did not set its cause flag");
	wdt_quiet_a: assert property (run & wdt_int & ~hold_req & ~dbg_rst |=> !sys_reset)
		else $error("watchdog interrupt option still gave a reset");
	por_low_a: assert property (!por_ok_s |=> sys_reset)
		else $error("reset released while power-on level is low");
	dbg_cause_a: assert property (run & dbg_rst |=> cause[rsc_pkg::CAUSE_DBG])
		else $error("debugger reset did not set its cause flag");
	lvd_off_a: assert property (!lvd_ctl[rsc_pkg::LVD_EN_BIT] |=> !lvd_irq)
		else $error("low voltage interrupt while disabled");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus acknowledge longer than one cycle");

	wdt_rst_c: cover property (run ##1 run & wdt_rst ##1 sys_reset);
	gpio_smr_c: cover property (stop_mode & gpio_edge & run ##1 smr_active);
	pin_rst_c: cover property ($rose(pin_act) ##[1:200] $fell(sys_reset));
	lvd_irq_c: cover property (lvd_irq);

endmodule : rsc_top

// file: tb/rsc_env.sv
// partner model: watchdog, supply comparators and external reset pin
`timescale 1ns/10ps
module rsc_env (
	// system
	input  wire logic clk,
	// far side levels and pulses
	output logic      reset_pin_n,
	output logic      supply_por_ok,
	output logic      brownout_detect,
	output logic      lvd_below,
	output logic      watchdog_timeout
);
	initial begin
		reset_pin_n      = 1'b1;
		supply_por_ok    = 1'b0;
		brownout_detect  = 1'b0;
		lvd_below        = 1'b0;
		watchdog_timeout = 1'b0;
	end

	// one-cycle time-out pulse
	task automatic wdt_fire();
		@(posedge clk) watchdog_timeout <= 1'b1;
		@(posedge clk) watchdog_timeout <= 1'b0;
	endtask : wdt_fire

	// pin low for n cycles, then back to the pull-up level
	task automatic pin_low(input int n);
		@(posedge clk) reset_pin_n <= 1'b0;
		repeat (n) @(posedge clk);
		reset_pin_n <= 1'b1;
	endtask : pin_low

	// por level lies above brownout level, so brownout implies low por
	task automatic supply(input logic por, input logic bo, input logic lv);
		@(posedge clk);
		supply_por_ok   <= por & ~bo;
		brownout_detect <= bo;
		lvd_below       <= lv;
	endtask : supply
endmodule : rsc_env

// file: tb/tb.sv
// testbench: reset sources, stop recovery and register bus of the reset controller
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
	$display("BAD %0t mismatch %h vs %h", $time, got, exp); end end
module tb;
	localparam logic [7:0] A_DBG = rsc_pkg::ADR_DBG;
	localparam logic [7:0] A_CAU = rsc_pkg::ADR_CAUSE;
	localparam logic [7:0] A_SMR = rsc_pkg::ADR_SMR_EN;
	localparam logic [7:0] A_LVD = rsc_pkg::ADR_LVD;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        pin_n, por_ok, bo, lvd, wdt;
	logic [7:0]  gpio = 8'h00;
	logic        wd_opt = 1'b1;
	logic        alt_en = 1'b0;
	logic        stop = 1'b0;
	logic        xtal = 1'b0;
	logic        sys_reset, smr_active, wdt_irq, lvd_irq;
	logic [2:0]  lvd_thr;
	int          errors = 0;
	int          check_count = 0;
	int          wi_n = 0;
	int          li_n = 0;

	always #20 clk = ~clk;
	always @(posedge clk) begin
		wi_n <= wi_n + int'(wdt_irq);
		li_n <= li_n + int'(lvd_irq);
	end

	rsc_env env_i (.clk(clk), .reset_pin_n(pin_n), .supply_por_ok(por_ok),
		.brownout_detect(bo), .lvd_below(lvd), .watchdog_timeout(wdt));

	rsc_top #(.XTAL_CYCLES(10)) rsc_top_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf),
		.wb_dat_o(rdat), .wb_ack_o(ack), .reset_pin_n(pin_n), .supply_por_ok(por_ok),
		.brownout_detect(bo), .lvd_below(lvd), .gpio_in(gpio), .watchdog_timeout(wdt),
		.watchdog_reset_select_option(wd_opt), .reset_pin_alt_en(alt_en),
		.stop_mode(stop), .xtal_enable(xtal), .sys_reset(sys_reset),
		.smr_active(smr_active), .wdt_irq(wdt_irq), .lvd_irq(lvd_irq),
		.lvd_threshold(lvd_thr));

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			errors++;
			$display("BAD %0t bus answer missing", $time);
		end
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask : wb

	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step

	// cycles that sys_reset stays high
	task automatic rst_len(output int n);
		n = 0;
		while (sys_reset !== 1'b0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (sys_reset !== 1'b0) begin
			errors++;
			$display("BAD %0t system reset never released", $time);
		end
	endtask : rst_len

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	initial begin
		#400000;
		errors++;
		$display("BAD %0t watchdog timeout", $time);
		complete_run();
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		int n0, n1, w0;
		logic [7:0] q;
		env_i.supply(1'b1, 1'b0, 1'b0);
		repeat (11) @(posedge clk);
		rst_n <= 1'b1;
		step(1);
		rst_len(n0);
		wb(1'b0, A_CAU, 8'h00, q);
		`CHK(q, rsc_pkg::CAUSE_RST_VAL)
		wb(1'b0, A_SMR, 8'h00, q);
		`CHK(q, rsc_pkg::SMR_EN_RST)
		wb(1'b0, 8'h10, 8'h00, q);
		`CHK(q, 8'h00)
		wb(1'b1, A_CAU, 8'hff, q);
		wb(1'b0, A_CAU, 8'h00, q);
		`CHK(q, 8'h00)
		$display("test reset done");
		env_i.wdt_fire();
		step(1);
		`CHK(sys_reset, 1'b1)
		rst_len(n0);
		`CHK(n0, int'(rsc_pkg::SYS_RST_CYCLES) + 1)
		wb(1'b0, A_CAU, 8'h00, q);
		`CHK(q, 8'h04)
		wb(1'b1, A_CAU, 8'hff, q);
		@(posedge clk) xtal <= 1'b1;
		env_i.wdt_fire();
		step(1);
		rst_len(n1);
		`CHK(n1 - n0, 10)
		@(posedge clk) xtal <= 1'b0;
		@(posedge clk) wd_opt <= 1'b0;
		w0 = wi_n;
		env_i.wdt_fire();
		step(4);
		`CHK(wi_n - w0, 1)
		`CHK(sys_reset, 1'b0)
		@(posedge clk) wd_opt <= 1'b1;
		$display("test watchdog done");
		wb(1'b1, A_CAU, 8'hff, q);
		wb(1'b1, A_DBG, 8'h01, q);
		step(2);
		`CHK(sys_reset, 1'b1)
		rst_len(n1);
		wb(1'b0, A_CAU, 8'h00, q);
		`CHK(q, 8'h10)
		wb(1'b1, A_CAU, 8'hff, q);
		$display("test debugger done");
		env_i.pin_low(8);
		step(6);
		`CHK(sys_reset, 1'b0)
		@(posedge clk) alt_en <= 1'b1;
		env_i.pin_low(3);
		step(6);
		`CHK(sys_reset, 1'b0)
		env_i.pin_low(6);
		step(4);
		`CHK(sys_reset, 1'b1)
		rst_len(n1);
		wb(1'b0, A_CAU, 8'h00, q);
		`CHK(q, 8'h08)
		wb(1'b1, A_CAU, 8'hff, q);
		$display("test pin done");
		env_i.supply(1'b0, 1'b1, 1'b0);
		step(5);
		`CHK(sys_reset, 1'b1)
		env_i.supply(1'b0, 1'b0, 1'b0);
		step(90);
		`CHK(sys_reset, 1'b1)
		env_i.supply(1'b1, 1'b0, 1'b0);
		step(1);
		rst_len(n1);
		wb(1'b0, A_CAU, 8'h00, q);
		`CHK(q, 8'h03)
		wb(1'b1, A_CAU, 8'hff, q);
		$display("test brownout done");
		wb(1'b1, A_SMR, 8'h04, q);
		@(posedge clk) stop <= 1'b1;
		@(posedge clk) gpio <= 8'h01;
		step(6);
		`CHK(smr_active, 1'b0)
		@(posedge clk) gpio <= 8'h05;
		step(4);
		`CHK(smr_active, 1'b1)
		`CHK(sys_reset, 1'b0)
		step(20);
		`CHK(smr_active, 1'b0)
		env_i.wdt_fire();
		step(3);
		`CHK(smr_active, 1'b1)
		`CHK(sys_reset, 1'b0)
		step(20);
		wb(1'b0, A_CAU, 8'h00, q);
		`CHK(q, 8'h24)
		@(posedge clk) stop <= 1'b0;
		$display("test stop recovery done");
		wb(1'b1, A_LVD, 8'h0d, q);
		`CHK(lvd_thr, 3'h5)
		wb(1'b0, A_LVD, 8'h00, q);
		`CHK(q, 8'h0d)
		w0 = li_n;
		env_i.supply(1'b1, 1'b0, 1'b1);
		step(6);
		`CHK(li_n - w0, 1)
		env_i.supply(1'b1, 1'b0, 1'b0);
		wb(1'b1, A_LVD, 8'h05, q);
		env_i.supply(1'b1, 1'b0, 1'b1);
		step(6);
		`CHK(li_n - w0, 1)
		$display("test low voltage done");
		complete_run();
	end
endmodule : tb
